// [bench/misc_exc_sequencer_test.sv]
module misc_exc_sequencer_test
    import seq_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_n_i = 1'b0, halt_n_i = 1'b0, req_valid_i = 1'b0;
    req_s req_i = '0;
    logic bus_wait_i, ready_o, req_error_o, busy_o, done_o;
    bus_s bus_o;
    logic [15:0] clocks_o;
    logic [3:0] reads_o, writes_o;
    logic [1:0] nwait = 2'h0;
    logic [31:0] seed = 32'h0000_E8CF;
    int fails = 0, num_checks = 0, n, i;
    // clocks, reads, writes per op code
    int cost [26] = '{16'h0410, 16'h1430, 16'h1430, 16'h1430, 16'h8410, 16'h0400,
        16'h1450, 16'h1040, 16'h1420, 16'h1022, 16'h0C30, 16'h1022, 16'h1040,
        16'h1824, 16'h1860, 16'h0A10, 16'h3247, 16'h3247, 16'h2243, 16'h2243,
        16'h2243, 16'h2243, 16'h2253, 16'h2843, 16'h2643, 16'h2C53};
    always #5 clk_i = ~clk_i;
    misc_exc_sequencer u_misc_exc_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .halt_n_i(halt_n_i), .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o),
        .req_error_o(req_error_o), .bus_wait_i(bus_wait_i), .bus_o(bus_o), .busy_o(busy_o),
        .done_o(done_o), .clocks_o(clocks_o), .reads_o(reads_o), .writes_o(writes_o));
    seq_bus_memory u_seq_bus_memory (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_o),
        .nwait_i(nwait), .wait_o(bus_wait_i));
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h7FFF_FFFF);
    endfunction
    task automatic test_done();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // bounded wait, n counts edges up to the done pulse
    task automatic wait_done();
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (done_o !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            fails++;
            test_done();
        end
    endtask
    task automatic run_op(input op_e op);
        int c, r, w, er, ec;
        er = xs() % 4;
        ec = 4 * er + 2 * (xs() % 3);
        c = cost[op] >> 8;
        r = (cost[op] >> 4) & 15;
        w = cost[op] & 15;
        if (op inside {OP_BOUNDS_CHECK_PASS, EX_BOUNDS_CHECK, EX_DIVIDE_ZERO})
        begin
            c += ec;
            r += er;
        end
        c += nwait * (r + w);
        for (i = 0; i < 50 && ready_o !== 1'b1; i++)
            @(posedge clk_i);
        if (ready_o !== 1'b1)
        begin
            fails++;
            test_done();
        end
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op, '{ec[7:0], er[3:0]}};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        wait_done();
        chk(16'(n), 16'(c));
        chk(clocks_o, 16'(c));
        chk(reads_o, 16'(r));
        chk(writes_o, 16'(w));
        chk(ready_o, 16'h0001);
        $display("op %0d waits %0d done", op, nwait);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
        chk(busy_o, 16'h0000);
        @(posedge clk_i);
        halt_n_i <= 1'b1;
        @(posedge clk_i);
        wait_done();
        chk(16'(n), 16'h0028);
        chk(clocks_o, 16'h0028);
        chk(reads_o, 16'h0006);
        chk(writes_o, 16'h0000);
        $display("boot done");
        for (int k = 0; k < 26; k++)
            run_op(op_e'(k));
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i.op <= op_e'(5'h1F);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk(req_error_o, 16'h0001);
        chk(busy_o, 16'h0000);
        $display("bad op done");
        repeat (30)
        begin
            nwait = 2'(xs() % 3);
            run_op(op_e'(xs() % 26));
        end
        test_done();
    end
endmodule // misc_exc_sequencer_test

// [bench/seq_bus_memory.sv]
module seq_bus_memory
    import seq_timing_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // system bus
    input wire bus_s bus_i,
    input wire logic [1:0] nwait_i,
    output logic wait_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_ff;
    logic [1:0] held_ff;
    logic cyc;
    assign cyc = bus_i.rd || bus_i.wr;
    // slow memory stretches only the last clock, acknowledge included
    assign wait_o = cyc && ph_ff == 2'h3 && held_ff < nwait_i;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !cyc)
        begin
            ph_ff <= 2'h0;
            held_ff <= 2'h0;
        end
        else if (wait_o)
        begin
            held_ff <= held_ff + 2'h1;
        end
        else
        begin
            ph_ff <= ph_ff + 2'h1;
            held_ff <= 2'h0;
        end
    end
endmodule // seq_bus_memory

// [bench/seq_timing_monitor.sv]
module seq_timing_monitor
    import seq_timing_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // request side
    input wire logic halt_n_i,
    input wire logic req_valid_i,
    input wire req_s req_i,
    input wire logic ready_o,
    input wire logic req_error_o,
    // bus and report
    input wire logic bus_wait_i,
    input wire bus_s bus_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [15:0] clocks_o,
    input wire logic [3:0] reads_o,
    input wire logic [3:0] writes_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = ready_o && req_valid_i && (req_i.op <= EX_INTERRUPT);
    property p_take;
        take |=> busy_o && !ready_o;
    endproperty
    a_take: assert property (p_take) else $error("request not launched");
    property p_stop;
        take && req_i.op == OP_STOP |=> busy_o [*4] ##1
            (done_o && clocks_o == 16'h0004 && reads_o == 4'h0 && writes_o == 4'h0);
    endproperty
    a_stop: assert property (p_stop) else $error("stop cost wrong");
    property p_bad;
        ready_o && req_valid_i && req_i.op > EX_INTERRUPT |=> req_error_o && !busy_o;
    endproperty
    a_bad: assert property (p_bad) else $error("bad op not refused");
    property p_end;
        $fell(busy_o) |-> done_o && ready_o;
    endproperty
    a_end: assert property (p_end) else $error("end without done");
    property p_idle;
        done_o |-> clocks_o >= (16'(reads_o) + 16'(writes_o)) * 16'h0004;
    endproperty
    a_idle: assert property (p_idle) else $error("bus cycles exceed total");
    property p_bus4;
        $rose(bus_o.rd || bus_o.wr) |-> (bus_o.rd || bus_o.wr) [*4];
    endproperty
    a_bus4: assert property (p_bus4) else $error("bus cycle short");
    property p_iack;
        take && req_i.op == EX_INTERRUPT |=> bus_o.iack && bus_o.rd;
    endproperty
    a_iack: assert property (p_iack) else $error("no acknowledge read");
    property p_prst;
        bus_o.periph_reset |-> busy_o && !bus_o.rd && !bus_o.wr;
    endproperty
    a_prst: assert property (p_prst) else $error("reset pulse on bus cycle");
    cover property (take && req_i.op == EX_INTERRUPT);
    cover property (bus_wait_i && bus_o.wr);
    cover property (req_error_o);
endmodule // seq_timing_monitor

bind misc_exc_sequencer seq_timing_monitor u_seq_timing_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .halt_n_i(halt_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .ready_o(ready_o), .req_error_o(req_error_o), .bus_wait_i(bus_wait_i),
    .bus_o(bus_o), .busy_o(busy_o), .done_o(done_o), .clocks_o(clocks_o),
    .reads_o(reads_o), .writes_o(writes_o));

// [rtl/misc_exc_sequencer.sv]
// What this block does
// - report clocks, reads and writes per operation
// - flagged entries add operand address cost
// - immediate logic to status: 20 clocks, 3/0
// - reset 132/1, stop 4/0, no-operation 4/1
// - returns, link and release take listed totals
// - peripheral moves take 16 or 24 clocks
// - exception totals include stacking, vector, first fetch
// - faults 50 (4/7); traps 34 (4/3), overflow trap 34 (5/3)
// - bounds 40, divide-zero 38, plus operand cost
// - interrupt 44 (5/3), acknowledge takes four clocks plus any wait states
// - boot sequence 40 clocks, 6 reads after release
module misc_exc_sequencer
    import seq_timing_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // start control
    input wire logic halt_n_i,
    // operation request
    input wire logic req_valid_i,
    input wire req_s req_i,
    output logic ready_o,
    output logic req_error_o,
    // bus cycle control
    input wire logic bus_wait_i,
    output bus_s bus_o,
    // progress and cost report
    output logic busy_o,
    output logic done_o,
    output logic [15:0] clocks_o,
    output logic [3:0] reads_o,
    output logic [3:0] writes_o
);

    // ------------------------------------------------------------
    // cost table
    // ------------------------------------------------------------
    function automatic cost_s cost_of(input op_e op, output logic bad);
        cost_s c;
        c = C_NOP;
        bad = 1'b0;
        unique case (op)
            OP_NO_OPERATION: c = C_NOP;
            OP_AND_IMMEDIATE,
            OP_XOR_IMMEDIATE,
            OP_OR_IMMEDIATE: c = C_IMM_SR;
            OP_RESET_INSTR: c = C_RESET_INSTR;
            OP_STOP: c = C_STOP;
            OP_EXCEPTION_RETURN: c = C_EXC_RETURN;
            OP_SUB_RETURN: c = C_SUB_RETURN;
            OP_RESTORE_AND_RETURN: c = C_RESTORE_RET;
            OP_FRAME_LINK: c = C_LINK;
            OP_FRAME_RELEASE: c = C_RELEASE;
            OP_PMOVE_WORD_TO_MEM: c = C_PMOVE_W_MEM;
            OP_PMOVE_WORD_TO_REG: c = C_PMOVE_W_REG;
            OP_PMOVE_LONG_TO_MEM: c = C_PMOVE_L_MEM;
            OP_PMOVE_LONG_TO_REG: c = C_PMOVE_L_REG;
            OP_BOUNDS_CHECK_PASS: c = C_BOUNDS_PASS;
            EX_BUS_FAULT,
            EX_ADDR_FAULT: c = C_EX_FAULT;
            EX_ILLEGAL,
            EX_PRIVILEGE,
            EX_TRACE,
            EX_SOFT_TRAP: c = C_EX_TRAP;
            EX_OVERFLOW_TRAP: c = C_EX_OVF_TRAP;
            EX_BOUNDS_CHECK: c = C_EX_BOUNDS;
            EX_DIVIDE_ZERO: c = C_EX_DIV0;
            EX_INTERRUPT: c = C_EX_INTERRUPT;
            default: bad = 1'b1;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // load a new operation into the sequencer
    // ------------------------------------------------------------
    // totals already hold stacking, vector and first handler fetch,
    // so exceptions need no extra phase beyond the table figure
    function automatic seq_s launch(input seq_s s, input cost_s c, input ea_cost_s ea,
                                    input logic is_int, input logic is_rst);
        seq_s r;
        ea_cost_s e;
        logic [8:0] total;
        logic [4:0] nrd;
        r = s;
        e = c.ea ? ea : '0;
        total = {1'b0, c.clocks} + {1'b0, e.clocks};
        nrd = {1'b0, c.reads} + {1'b0, e.reads};
        r.st = ST_RUN;
        r.rd_left = nrd[3:0];
        r.wr_left = c.writes;
        r.ph = 2'h0;
        // operand address computation never writes, so only reads come off
        r.idle_left = 9'(total - BUS_CLKS * 9'({5'h00, nrd[3:0]} + {5'h00, c.writes}));
        r.clk_cnt = 16'h0000;
        r.rd_cnt = 4'h0;
        r.wr_cnt = 4'h0;
        r.is_int = is_int;
        r.is_rst = is_rst;
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_s state_ff;
    seq_s nxt_state;

    always_comb
    begin
        logic bad;
        cost_s c;
        bad = 1'b0;
        c = C_NOP;
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        nxt_state.err = 1'b0;
        unique case (state_ff.st)
            ST_BOOT:
            begin
                // synchronous reset already released; wait for halt negated
                if (halt_n_i)
                begin
                    nxt_state = launch(nxt_state, C_BOOT, '0, 1'b0, 1'b0);
                end
            end
            ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    c = cost_of(req_i.op, bad);
                    if (bad)
                    begin
                        nxt_state.err = 1'b1;
                    end
                    else
                    begin
                        nxt_state = launch(nxt_state, c, req_i.ea,
                                           req_i.op == EX_INTERRUPT,
                                           req_i.op == OP_RESET_INSTR);
                    end
                end
            end
            ST_RUN:
            begin
                nxt_state.clk_cnt = state_ff.clk_cnt + 16'h0001;
                if (state_ff.rd_left != 4'h0 || state_ff.wr_left != 4'h0)
                begin
                    if (state_ff.ph != BUS_LAST_PH)
                    begin
                        nxt_state.ph = state_ff.ph + 2'h1;
                    end
                    else if (!bus_wait_i)
                    begin
                        // reads first, then writes
                        nxt_state.ph = 2'h0;
                        if (state_ff.rd_left != 4'h0)
                        begin
                            nxt_state.rd_left = state_ff.rd_left - 4'h1;
                            nxt_state.rd_cnt = state_ff.rd_cnt + 4'h1;
                        end
                        else
                        begin
                            nxt_state.wr_left = state_ff.wr_left - 4'h1;
                            nxt_state.wr_cnt = state_ff.wr_cnt + 4'h1;
                        end
                    end
                end
                else if (state_ff.idle_left != 9'h000)
                begin
                    nxt_state.idle_left = state_ff.idle_left - 9'h001;
                end
                if (nxt_state.rd_left == 4'h0 && nxt_state.wr_left == 4'h0
                    && nxt_state.idle_left == 9'h000)
                begin
                    nxt_state.st = ST_IDLE;
                    nxt_state.done = 1'b1;
                end
            end
            default:
            begin
                nxt_state.st = ST_IDLE;
            end
        endcase
        nxt_state.ready = nxt_state.st == ST_IDLE;
        nxt_state.busy = nxt_state.st == ST_RUN;
        nxt_state.bus.rd = nxt_state.busy && nxt_state.rd_left != 4'h0;
        nxt_state.bus.wr = nxt_state.busy && nxt_state.rd_left == 4'h0
                           && nxt_state.wr_left != 4'h0;
        // first read of an interrupt is the acknowledge cycle, four clocks plus any wait states
        nxt_state.bus.iack = nxt_state.bus.rd && nxt_state.is_int
                             && nxt_state.rd_cnt == 4'h0;
        // peripherals are held in reset over the long internal stretch
        nxt_state.bus.periph_reset = nxt_state.busy && nxt_state.is_rst
                                     && !nxt_state.bus.rd && !nxt_state.bus.wr;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= SEQ_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ready_o = state_ff.ready;
    assign req_error_o = state_ff.err;
    assign bus_o = state_ff.bus;
    assign busy_o = state_ff.busy;
    assign done_o = state_ff.done;
    assign clocks_o = state_ff.clk_cnt;
    assign reads_o = state_ff.rd_cnt;
    assign writes_o = state_ff.wr_cnt;

endmodule // misc_exc_sequencer

// [rtl/seq_timing_pkg.sv]
package seq_timing_pkg;

    // ------------------------------------------------------------
    // operations and exceptions the sequencer times
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NO_OPERATION,
        OP_AND_IMMEDIATE,
        OP_XOR_IMMEDIATE,
        OP_OR_IMMEDIATE,
        OP_RESET_INSTR,
        OP_STOP,
        OP_EXCEPTION_RETURN,
        OP_SUB_RETURN,
        OP_RESTORE_AND_RETURN,
        OP_FRAME_LINK,
        OP_FRAME_RELEASE,
        OP_PMOVE_WORD_TO_MEM,
        OP_PMOVE_WORD_TO_REG,
        OP_PMOVE_LONG_TO_MEM,
        OP_PMOVE_LONG_TO_REG,
        OP_BOUNDS_CHECK_PASS,
        EX_BUS_FAULT,
        EX_ADDR_FAULT,
        EX_ILLEGAL,
        EX_PRIVILEGE,
        EX_TRACE,
        EX_SOFT_TRAP,
        EX_OVERFLOW_TRAP,
        EX_BOUNDS_CHECK,
        EX_DIVIDE_ZERO,
        EX_INTERRUPT
    } op_e;

    typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_RUN} seq_st_e;

    // ------------------------------------------------------------
    // cost carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] clocks;
        logic [3:0] reads;
        logic [3:0] writes;
        logic ea;
    } cost_s;

    typedef struct packed {
        logic [7:0] clocks;
        logic [3:0] reads;
    } ea_cost_s;

    typedef struct packed {
        op_e op;
        ea_cost_s ea;
    } req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic iack;
        logic periph_reset;
    } bus_s;

    localparam logic [1:0] BUS_LAST_PH = 2'h3;
    localparam logic [8:0] BUS_CLKS = 9'h004;

    localparam cost_s C_NOP = '{8'h04, 4'h1, 4'h0, 1'b0};
    localparam cost_s C_IMM_SR = '{8'h14, 4'h3, 4'h0, 1'b0};
    localparam cost_s C_RESET_INSTR = '{8'h84, 4'h1, 4'h0, 1'b0};
    localparam cost_s C_STOP = '{8'h04, 4'h0, 4'h0, 1'b0};
    localparam cost_s C_EXC_RETURN = '{8'h14, 4'h5, 4'h0, 1'b0};
    localparam cost_s C_SUB_RETURN = '{8'h10, 4'h4, 4'h0, 1'b0};
    localparam cost_s C_RESTORE_RET = '{8'h14, 4'h2, 4'h0, 1'b0};
    localparam cost_s C_LINK = '{8'h10, 4'h2, 4'h2, 1'b0};
    localparam cost_s C_RELEASE = '{8'h0C, 4'h3, 4'h0, 1'b0};
    localparam cost_s C_PMOVE_W_MEM = '{8'h10, 4'h2, 4'h2, 1'b0};
    localparam cost_s C_PMOVE_W_REG = '{8'h10, 4'h4, 4'h0, 1'b0};
    localparam cost_s C_PMOVE_L_MEM = '{8'h18, 4'h2, 4'h4, 1'b0};
    localparam cost_s C_PMOVE_L_REG = '{8'h18, 4'h6, 4'h0, 1'b0};
    localparam cost_s C_BOUNDS_PASS = '{8'h0A, 4'h1, 4'h0, 1'b1};
    localparam cost_s C_EX_FAULT = '{8'h32, 4'h4, 4'h7, 1'b0};
    localparam cost_s C_EX_TRAP = '{8'h22, 4'h4, 4'h3, 1'b0};
    localparam cost_s C_EX_OVF_TRAP = '{8'h22, 4'h5, 4'h3, 1'b0};
    localparam cost_s C_EX_BOUNDS = '{8'h28, 4'h4, 4'h3, 1'b1};
    localparam cost_s C_EX_DIV0 = '{8'h26, 4'h4, 4'h3, 1'b1};
    localparam cost_s C_EX_INTERRUPT = '{8'h2C, 4'h5, 4'h3, 1'b0};
    localparam cost_s C_BOOT = '{8'h28, 4'h6, 4'h0, 1'b0};

    // ------------------------------------------------------------
    // whole sequencer state
    // ------------------------------------------------------------
    typedef struct packed {
        seq_st_e st;
        logic [3:0] rd_left;
        logic [3:0] wr_left;
        logic [1:0] ph;
        logic [8:0] idle_left;
        logic [15:0] clk_cnt;
        logic [3:0] rd_cnt;
        logic [3:0] wr_cnt;
        logic is_int;
        logic is_rst;
        logic ready;
        logic busy;
        logic done;
        logic err;
        bus_s bus;
    } seq_s;

    localparam seq_s SEQ_RESET = '{ST_BOOT, 4'h0, 4'h0, 2'h0, 9'h000, 16'h0000,
        4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0};

endpackage
